// ==== logic/psq_top.sv ====
// Rail sequencing, fault shutdown and sleep control of the power chip.
// Assumes comparator and pin inputs are asynchronous to SYS_CLK.
`timescale 1ns/1ns
module psq_top #(
    parameter int UVLO_DLY = psq_pkg::UVLO_DLY_CYC,
    parameter int OT_DLY   = psq_pkg::OT_DLY_CYC,
    parameter int STEP_DLY = psq_pkg::STEP_DLY_CYC
) (
    // Clock and reset
    input  wire logic               SYS_CLK,
    input  wire logic               RESET,
    // Register port
    input  wire logic [3:0]         REG_ADDR,
    input  wire logic [7:0]         REG_WDATA,
    input  wire logic               REG_WR,
    input  wire logic               REG_RD,
    output logic      [7:0]         REG_RDATA,
    // Pins and comparators
    input  wire logic               SUPPLY_ORDER_SELECT,
    input  wire logic               CORE_DEFAULT_SELECT,
    input  wire logic               MAIN_DEFAULT_SELECT,
    input  wire logic               SLEEP_REQUEST_PIN,
    input  wire logic               PUSHBUTTON_WAKE,
    input  wire logic               WARM_RESTART_PIN_N,
    input  wire psq_pkg::psq_sense_t SENSE,
    // Outputs
    output psq_pkg::psq_rails_t     RAILS,
    output logic                    SUPPLY_FAIL_N,
    output logic                    IRQ,
    output logic                    SLEEP_MODE,
    output logic                    WAIT_MODE,
    output logic                    CHG_ENABLE,
    output logic      [11:0]        CORE_VSET_MV,
    output logic      [11:0]        MAIN_VSET_MV,
    output logic      [7:0]         UVLO_CODE,
    output logic      [7:0]         CORE_SLEEP_CODE
);
    localparam int CW = 24;
    initial begin
        if (UVLO_DLY < 1 || OT_DLY < 1 || STEP_DLY < 1 ||
            UVLO_DLY >= (1 << CW) || OT_DLY >= (1 << CW) ||
            STEP_DLY >= (1 << CW))
            $error("psq_top: delay parameter out of range");
    end

    // Two-stage synchronisers for all asynchronous inputs except the core and main default select pins
    localparam int NS = 12;
    logic [NS-1:0] async_in, sync1_reg, sync2_reg;
    assign async_in = {SENSE, SUPPLY_ORDER_SELECT, SLEEP_REQUEST_PIN,
                       PUSHBUTTON_WAKE};
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= async_in;
            sync2_reg <= sync1_reg;
        end
    end
    logic warm1_reg, warm2_reg;
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            warm1_reg <= 1'b1;
            warm2_reg <= 1'b1;
        end else begin
            warm1_reg <= WARM_RESTART_PIN_N;
            warm2_reg <= warm1_reg;
        end
    end
    psq_pkg::psq_sense_t s;
    logic order_sel, sleep_pin, pb_wake, warm_act;
    assign s         = psq_pkg::psq_sense_t'(sync2_reg[NS-1:3]);
    assign order_sel = sync2_reg[2];
    assign sleep_pin = sync2_reg[1];
    assign pb_wake   = sync2_reg[0];
    assign warm_act  = ~warm2_reg;

    // Software registers
    logic [7:0] conv_a_reg, conv_a_next, conv_b_reg, conv_b_next;
    logic [7:0] ldo_reg, ldo_next, uvlo_reg, uvlo_next;
    logic [7:0] chg_reg, chg_next;
    always_comb begin
        conv_a_next = conv_a_reg;
        conv_b_next = conv_b_reg;
        ldo_next    = ldo_reg;
        uvlo_next   = uvlo_reg;
        chg_next    = chg_reg;
        if (REG_WR) begin
            case (REG_ADDR)
                // RL19 fixed-frequency bit
                psq_pkg::ADDR_CONV_A:   conv_a_next = REG_WDATA;
                psq_pkg::ADDR_CONV_B:   conv_b_next = REG_WDATA;
                // RL2 regulator reprogram
                psq_pkg::ADDR_LDO_CTRL: ldo_next = REG_WDATA;
                // RL6 threshold reprogram
                psq_pkg::ADDR_UVLO:     uvlo_next = REG_WDATA;
                psq_pkg::ADDR_CHG_CFG:  chg_next = REG_WDATA;
                default: ;
            endcase
        end
    end
    // RL2 RL6 reset defaults
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            conv_a_reg <= psq_pkg::RST_CONV_A;
            conv_b_reg <= psq_pkg::RST_CONV_B;
            ldo_reg    <= psq_pkg::RST_LDO_CTRL;
            uvlo_reg   <= psq_pkg::RST_UVLO;
            chg_reg    <= psq_pkg::RST_CHG_CFG;
        end else begin
            conv_a_reg <= conv_a_next;
            conv_b_reg <= conv_b_next;
            ldo_reg    <= ldo_next;
            uvlo_reg   <= uvlo_next;
            chg_reg    <= chg_next;
        end
    end
    logic fixed_freq_force, sleep_allow, sleep_core_off, wait_allow;
    logic ldo1_sw, ldo_two_sw;
    assign fixed_freq_force = conv_a_reg[psq_pkg::BIT_FIXED_FREQ];
    assign sleep_allow      = conv_a_reg[psq_pkg::BIT_SLEEP_ALLOW];
    assign sleep_core_off   = conv_b_reg[psq_pkg::BIT_CORE_OFF];
    assign ldo1_sw          = ldo_reg[psq_pkg::BIT_LDO1_EN];
    assign ldo_two_sw       = ldo_reg[psq_pkg::BIT_LDO_TWO_EN];
    assign wait_allow       = chg_reg[psq_pkg::BIT_WAIT_ALLOW];

    // Fault qualification
    logic ot_fault, uv_fault, any_fault;
    // RL1 temperature gated by fixed frequency
    assign ot_fault  = s.over_temp & (fixed_freq_force | s.auto_fixed);
    assign uv_fault  = s.below_uvlo;
    assign any_fault = ot_fault | uv_fault;

    // Sequencer with shared delay counter
    psq_pkg::psq_seq_t st_reg, st_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic [1:0] on_reg, on_next; // [0] first rail, [1] second rail
    logic fail_reg, fail_next;
    logic [CW-1:0] fault_dly;
    assign fault_dly = uv_fault ? CW'(UVLO_DLY) : CW'(OT_DLY);
    always_comb begin
        st_next   = st_reg;
        cnt_next  = cnt_reg;
        on_next   = on_reg;
        fail_next = any_fault;
        case (st_reg)
            // RL9 automatic restart
            psq_pkg::SEQ_OFF: if (!any_fault) begin
                st_next = psq_pkg::SEQ_UP1;
                cnt_next = CW'(STEP_DLY);
            end
            psq_pkg::SEQ_UP1: begin
                on_next[0] = 1'b1;
                if (cnt_reg == '0) st_next = psq_pkg::SEQ_UP2;
                else cnt_next = cnt_reg - 1'b1;
            end
            psq_pkg::SEQ_UP2: begin
                on_next[1] = 1'b1;
                st_next = psq_pkg::SEQ_ON;
            end
            // RL7 RL8 fail flag then delay
            psq_pkg::SEQ_ON: if (any_fault) begin
                st_next = psq_pkg::SEQ_FAIL_WAIT;
                cnt_next = fault_dly;
            end
            psq_pkg::SEQ_FAIL_WAIT: begin
                // RL20 cancel if fault clears
                if (!any_fault) st_next = psq_pkg::SEQ_ON;
                else if (cnt_reg == '0) begin
                    st_next = psq_pkg::SEQ_DN1;
                    cnt_next = CW'(STEP_DLY);
                end else cnt_next = cnt_reg - 1'b1;
            end
            // RL10 second rail down first
            psq_pkg::SEQ_DN1: begin
                on_next[1] = 1'b0;
                if (cnt_reg == '0) st_next = psq_pkg::SEQ_DN2;
                else cnt_next = cnt_reg - 1'b1;
            end
            psq_pkg::SEQ_DN2: begin
                on_next[0] = 1'b0;
                st_next = psq_pkg::SEQ_OFF;
            end
            default: st_next = psq_pkg::SEQ_OFF;
        endcase
    end
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            st_reg   <= psq_pkg::SEQ_OFF;
            cnt_reg  <= '0;
            on_reg   <= 2'b00;
            fail_reg <= 1'b1;
        end else begin
            st_reg   <= st_next;
            cnt_reg  <= cnt_next;
            on_reg   <= on_next;
            fail_reg <= fail_next;
        end
    end

    // Sleep and wait mode
    logic sleep_req, sleep_req_reg, lp_reg, lp_next, wait_reg, wait_next;
    assign sleep_req = sleep_pin & sleep_allow;
    always_comb begin
        lp_next = lp_reg;
        // RL15 forced exit
        if (!sleep_pin || !sleep_allow || pb_wake || warm_act)
            lp_next = 1'b0;
        // RL14 RL16 rising edge only
        else if (sleep_req && !sleep_req_reg)
            lp_next = 1'b1;
        // RL17 wait needs allow with external supply
        wait_next = sleep_pin & (!s.ext_supply | wait_allow);
    end
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            sleep_req_reg <= 1'b0;
            lp_reg        <= 1'b0;
            wait_reg      <= 1'b0;
        end else begin
            sleep_req_reg <= sleep_req;
            lp_reg        <= lp_next;
            wait_reg      <= wait_next;
        end
    end

    // Output registers
    psq_pkg::psq_rails_t rails_next;
    logic [1:0] pg_next;
    logic [11:0] core_mv_next, main_mv_next;
    logic irq_next;
    logic [1:0] pg_reg;
    logic [11:0] core_mv_reg, main_mv_reg;
    logic [7:0] rdata_next;
    always_comb begin
        // RL10 order select maps first rail
        rails_next.core_en = order_sel ? on_reg[1] : on_reg[0];
        rails_next.main_en = order_sel ? on_reg[0] : on_reg[1];
        // RL13 core off in sleep if asked
        if (lp_reg && sleep_core_off) rails_next.core_en = 1'b0;
        rails_next.ldo1_en = ldo1_sw & (st_reg == psq_pkg::SEQ_ON);
        rails_next.ldo_two_en = ldo_two_sw & (st_reg == psq_pkg::SEQ_ON);
        // RL3 power-good per regulator; RL5 masked when off
        pg_next = {ldo_two_sw & s.ldo_two_ok, s.ldo1_ok};
        // RL4 interrupt on low rail
        irq_next = s.ldo1_low | (ldo_two_sw & s.ldo_two_low);
        // RL11 RL12 default voltages
        core_mv_next = CORE_DEFAULT_SELECT ? psq_pkg::CORE_MV_HI
                                           : psq_pkg::CORE_MV_LO;
        main_mv_next = MAIN_DEFAULT_SELECT ? psq_pkg::MAIN_MV_HI
                                           : psq_pkg::MAIN_MV_LO;
        case (REG_ADDR)
            psq_pkg::ADDR_CONV_A:   rdata_next = conv_a_reg;
            psq_pkg::ADDR_CONV_B:   rdata_next = conv_b_reg;
            psq_pkg::ADDR_LDO_CTRL: rdata_next = ldo_reg;
            psq_pkg::ADDR_STATUS:   rdata_next = {6'h00, pg_reg};
            psq_pkg::ADDR_UVLO:     rdata_next = uvlo_reg;
            psq_pkg::ADDR_CHG_CFG:  rdata_next = chg_reg;
            psq_pkg::ADDR_RAILS:    rdata_next = {4'h0, RAILS};
            default:                rdata_next = 8'h00;
        endcase
        if (!REG_RD) rdata_next = 8'h00;
    end
    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            RAILS           <= '0;
            pg_reg          <= 2'b00;
            IRQ             <= 1'b0;
            SUPPLY_FAIL_N   <= 1'b0;
            SLEEP_MODE      <= 1'b0;
            WAIT_MODE       <= 1'b0;
            CHG_ENABLE      <= 1'b0;
            core_mv_reg     <= psq_pkg::CORE_MV_LO;
            main_mv_reg     <= psq_pkg::MAIN_MV_LO;
            UVLO_CODE       <= psq_pkg::RST_UVLO;
            CORE_SLEEP_CODE <= psq_pkg::RST_CONV_B;
            REG_RDATA       <= 8'h00;
        end else begin
            RAILS           <= rails_next;
            pg_reg          <= pg_next;
            IRQ             <= irq_next;
            // RL7 RL8 fail pin low during fault
            SUPPLY_FAIL_N   <= ~fail_reg;
            // RL13 sleep preset to core converter
            SLEEP_MODE      <= lp_reg;
            WAIT_MODE       <= wait_reg;
            // RL18 independent charger lockout
            CHG_ENABLE      <= s.chg_uvlo_ok;
            core_mv_reg     <= core_mv_next;
            main_mv_reg     <= main_mv_next;
            UVLO_CODE       <= uvlo_reg;
            CORE_SLEEP_CODE <= {1'b0, conv_b_reg[6:0]};
            REG_RDATA       <= rdata_next;
        end
    end
    assign CORE_VSET_MV = core_mv_reg;
    assign MAIN_VSET_MV = main_mv_reg;

    // Assertions
    property p_ot_gate;
        @(posedge SYS_CLK) disable iff (RESET)
        (st_reg == psq_pkg::SEQ_ON && s.over_temp && !s.below_uvlo &&
         !fixed_freq_force && !s.auto_fixed) |=>
        (st_reg == psq_pkg::SEQ_ON);
    endproperty
    a_ot_gate: assert property (p_ot_gate) // RL1
        else $error("overtemp acted outside fixed frequency");
    property p_fail_low;
        @(posedge SYS_CLK) disable iff (RESET)
        (st_reg == psq_pkg::SEQ_FAIL_WAIT && any_fault) |=> ##1
        !SUPPLY_FAIL_N;
    endproperty
    a_fail_low: assert property (p_fail_low) // RL7
        else $error("fail pin not low during fault wait");
    property p_cancel;
        @(posedge SYS_CLK) disable iff (RESET)
        (st_reg == psq_pkg::SEQ_FAIL_WAIT && !any_fault) |=>
        (st_reg == psq_pkg::SEQ_ON);
    endproperty
    a_cancel: assert property (p_cancel) // RL20
        else $error("shutdown not cancelled");
    property p_lp_edge;
        @(posedge SYS_CLK) disable iff (RESET)
        $rose(lp_reg) |-> $past(sleep_req) && !$past(sleep_req_reg);
    endproperty
    a_lp_edge: assert property (p_lp_edge) // RL14
        else $error("sleep entered without rising edge");
    property p_lp_exit;
        @(posedge SYS_CLK) disable iff (RESET)
        (lp_reg && (pb_wake || warm_act || !sleep_allow)) |=> !lp_reg;
    endproperty
    a_lp_exit: assert property (p_lp_exit) // RL15
        else $error("sleep not left on wake event");
    property p_ldo_two_irq;
        @(posedge SYS_CLK) disable iff (RESET)
        (!ldo_two_sw && !s.ldo1_low) |=> !IRQ;
    endproperty
    a_ldo_two_irq: assert property (p_ldo_two_irq) // RL5
        else $error("disabled regulator raised interrupt");
    property p_irq;
        @(posedge SYS_CLK) disable iff (RESET)
        s.ldo1_low |=> IRQ;
    endproperty
    a_irq: assert property (p_irq) // RL4
        else $error("low rail did not interrupt");
    property p_core_off;
        @(posedge SYS_CLK) disable iff (RESET)
        (lp_reg && sleep_core_off) |=> !RAILS.core_en;
    endproperty
    a_core_off: assert property (p_core_off) // RL13
        else $error("core on during sleep with core off");
    property p_wait;
        @(posedge SYS_CLK) disable iff (RESET)
        (sleep_pin && s.ext_supply && !wait_allow) |=> !wait_reg;
    endproperty
    a_wait: assert property (p_wait) // RL17
        else $error("wait entered without allow");
    c_fault: cover property (@(posedge SYS_CLK) disable iff (RESET)
        st_reg == psq_pkg::SEQ_DN2);
    c_sleep: cover property (@(posedge SYS_CLK) disable iff (RESET)
        $rose(lp_reg));
    c_cancel: cover property (@(posedge SYS_CLK) disable iff (RESET)
        st_reg == psq_pkg::SEQ_FAIL_WAIT && !any_fault);
endmodule : psq_top

// ==== logic/psq_pkg.sv ====
// Package of constants and carriers for the rail sequencing controller.
// Assumes a single 250 MHz clock and a plain register port.
//
// Functional notes
// RL1: Overtemperature only evaluated while converters run fixed-frequency, forced or automatic.
// RL2: Both linear regulators enabled after reset; software may disable or reprogram.
// RL3: Each linear regulator power-good with hysteresis, readable in status register.
// RL4: Interrupt raised when any monitored rail drops below power-good threshold.
// RL5: Disabled second linear regulator reports no fault and raises no interrupt.
// RL6: Lockout threshold resets to 2.75 V code; software may reprogram later.
// RL7: Supply below lockout drives fail low, then rails off after delay; ldo1_en and ldo_two_en go off with fail, without the delay.
// RL8: Overtemperature runs same procedure: fail low, delay, ordered shutdown.
// RL9: Rails restart automatically once the fault condition has cleared.
// RL10: Order select 0 ramps core first, down last; 1 ramps main first.
// RL11: Core default voltage from select pin: low 1.5 V, high 1.8 V.
// RL12: Main default voltage from select pin: low 3 V, high 3.3 V.
// RL13: Low-power lowers core to sleep preset, or turns core off if set.
// RL14: Enter low-power only on rising edge of request pin AND allow bit.
// RL15: Leave low-power on request low, allow cleared, pushbutton or warm restart.
// RL16: Processor re-enters low-power only through a fresh rising edge.
// RL17: Request pin enters wait mode; with external supply wait_allow must be set.
// RL18: Charger has its own independent lockout, nominally 2.5 V, on external inputs.
// RL19: Bit 7 of converter_ctrl_a forces both converters into fixed frequency; the bit drives no converter output, it only gates overtemperature (RL1).
// RL20: Shutdown delays are parameterised counters; cancelled if fault clears early.
package psq_pkg;
    // Register offsets
    localparam logic [3:0] ADDR_CONV_A   = 4'h0;
    localparam logic [3:0] ADDR_CONV_B   = 4'h1;
    localparam logic [3:0] ADDR_LDO_CTRL = 4'h2;
    localparam logic [3:0] ADDR_STATUS   = 4'h3;
    localparam logic [3:0] ADDR_UVLO     = 4'h4;
    localparam logic [3:0] ADDR_CHG_CFG  = 4'h5;
    localparam logic [3:0] ADDR_RAILS    = 4'h6;
    // Field positions
    localparam int BIT_FIXED_FREQ  = 7;
    localparam int BIT_SLEEP_ALLOW = 6;
    localparam int BIT_CORE_OFF    = 7;
    localparam int BIT_LDO1_EN     = 7;
    localparam int BIT_LDO_TWO_EN  = 6;
    localparam int BIT_WAIT_ALLOW  = 7;
    // Reset values
    localparam logic [7:0] RST_CONV_A   = 8'h00;
    localparam logic [7:0] RST_CONV_B   = 8'h00;
    localparam logic [7:0] RST_LDO_CTRL = 8'hc0;
    localparam logic [7:0] RST_UVLO     = 8'h03; // Code of 2.75 V
    localparam logic [7:0] RST_CHG_CFG  = 8'h00;
    // Default voltage codes, millivolts
    localparam logic [11:0] CORE_MV_LO = 12'h5dc; // 1.5 V
    localparam logic [11:0] CORE_MV_HI = 12'h708; // 1.8 V
    localparam logic [11:0] MAIN_MV_LO = 12'hbb8; // 3 V
    localparam logic [11:0] MAIN_MV_HI = 12'hce4; // 3.3 V
    // Timing: delays in microseconds, clock in MHz
    localparam int CLK_MHZ       = 250;
    localparam int UVLO_DLY_US   = 20;
    localparam int OT_DLY_US     = 20;
    localparam int STEP_DLY_US   = 10;
    localparam int UVLO_DLY_CYC  = UVLO_DLY_US * CLK_MHZ;
    localparam int OT_DLY_CYC    = OT_DLY_US * CLK_MHZ;
    localparam int STEP_DLY_CYC  = STEP_DLY_US * CLK_MHZ;

    // Sequencer states
    typedef enum logic [2:0] {
        SEQ_OFF, SEQ_UP1, SEQ_UP2, SEQ_ON, SEQ_FAIL_WAIT, SEQ_DN1, SEQ_DN2
    } psq_seq_t;

    // Analog comparator inputs
    typedef struct packed {
        logic below_uvlo;
        logic over_temp;
        logic auto_fixed;
        logic ldo1_low;
        logic ldo1_ok;
        logic ldo_two_low;
        logic ldo_two_ok;
        logic ext_supply;
        logic chg_uvlo_ok;
    } psq_sense_t;

    // Rail enables
    typedef struct packed {
        logic core_en;
        logic main_en;
        logic ldo1_en;
        logic ldo_two_en;
    } psq_rails_t;
endpackage : psq_pkg

// ==== verif/psq_proc_model.sv ====
// Processor-side model driving the sleep request and wake pins.
// Assumes the bench calls its tasks; pins change after rising edges.
`timescale 1ns/1ns
module psq_proc_model (
    // Clock
    input  wire logic clk,
    // Pins towards the sequencer
    output logic      sleep_pin,
    output logic      wake,
    output logic      warm_n
);
    // Idle levels: no request, no wake, restart released
    initial begin
        sleep_pin = 1'b0;
        wake      = 1'b0;
        warm_n    = 1'b1;
    end

    // Level of the sleep request pin
    task set_sleep(input logic v);
        @(posedge clk);
        sleep_pin <= v;
    endtask : set_sleep

    task toggle_sleep;
        set_sleep(1'b0);
        repeat (4) @(posedge clk);
        sleep_pin <= 1'b1;
    endtask : toggle_sleep

    task press_wake;
        @(posedge clk);
        wake <= 1'b1;
        repeat (4) @(posedge clk);
        wake <= 1'b0;
    endtask : press_wake

    task warm_pulse;
        @(posedge clk);
        warm_n <= 1'b0;
        repeat (4) @(posedge clk);
        warm_n <= 1'b1;
    endtask : warm_pulse
endmodule : psq_proc_model

// ==== verif/psq_top_tb_top.sv ====
// Bench of the rail sequencer: registers, faults, order and sleep.
// Assumes short delay parameters and the processor model for pins.
`timescale 1ns/1ns
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
    errors++; $display("[ERR] %s exp %h got %h", n, e, g); end end
`define WAITC(c, n) for (int k = 0; k < (n) && !(c); k++) wt(1);
module psq_top_tb_top;
    logic                clk, rst, wr, rd, order_sel, slp, wake, warm_n;
    logic                core_sel, main_sel;
    logic [3:0]          addr;
    logic [7:0]          wdata, rdata, uvlo, slp_code;
    logic                fail_n, irq, slp_mode, wait_mode, chg_en;
    logic [11:0]         core_mv, main_mv;
    psq_pkg::psq_sense_t sense;
    psq_pkg::psq_rails_t rails;
    int                  errors, checks_done, cycles;

    psq_top #(.UVLO_DLY(6), .OT_DLY(8), .STEP_DLY(4)) i_dut (
        .SYS_CLK(clk), .RESET(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
        .SUPPLY_ORDER_SELECT(order_sel), .CORE_DEFAULT_SELECT(core_sel),
        .MAIN_DEFAULT_SELECT(main_sel), .SLEEP_REQUEST_PIN(slp),
        .PUSHBUTTON_WAKE(wake), .WARM_RESTART_PIN_N(warm_n),
        .SENSE(sense), .RAILS(rails), .SUPPLY_FAIL_N(fail_n), .IRQ(irq),
        .SLEEP_MODE(slp_mode), .WAIT_MODE(wait_mode), .CHG_ENABLE(chg_en),
        .CORE_VSET_MV(core_mv), .MAIN_VSET_MV(main_mv),
        .UVLO_CODE(uvlo), .CORE_SLEEP_CODE(slp_code));
    psq_proc_model i_proc (.clk(clk), .sleep_pin(slp), .wake(wake),
        .warm_n(warm_n));

    // Clock of 4 ns
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            report_and_stop();
        end
    end

    task wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wt
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        `CHK("rdata", e, rdata)
    endtask : rd_chk

    // Fault entry, ordered shutdown and automatic restart
    task fault(input logic ot, input logic ord);
        @(posedge clk);
        order_sel <= ord;
        sense.over_temp <= ot;
        sense.below_uvlo <= !ot;
        `WAITC(!fail_n, 10)
        `CHK("fail_n", 1'b0, fail_n)
        `CHK("held", 2'b11, {rails.core_en, rails.main_en})
        `WAITC(!(ord ? rails.core_en : rails.main_en), 30)
        `CHK("dn1", ord ? 2'b01 : 2'b10, {rails.core_en, rails.main_en})
        `WAITC(!rails.core_en && !rails.main_en, 20)
        `CHK("dn2", 2'b00, {rails.core_en, rails.main_en})
        @(posedge clk);
        sense.over_temp <= 1'b0;
        sense.below_uvlo <= 1'b0;
        `WAITC(rails.core_en || rails.main_en, 30)
        `CHK("up1", ord ? 2'b01 : 2'b10, {rails.core_en, rails.main_en})
        `WAITC(rails.core_en && rails.main_en, 20)
        `CHK("up2", 2'b11, {rails.core_en, rails.main_en})
    endtask : fault

    task report_and_stop;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    // Main sequence
    initial begin
        rst = 1'b1;
        {wr, rd, order_sel, core_sel, main_sel, addr, wdata} = '0;
        sense = '0;
        {sense.ldo1_ok, sense.ldo_two_ok, sense.chg_uvlo_ok} = 3'b111;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        wt(1);
        `CHK("uvlo", psq_pkg::RST_UVLO, uvlo)
        `CHK("core", psq_pkg::CORE_MV_LO, core_mv)
        `CHK("main", psq_pkg::MAIN_MV_LO, main_mv)
        // Startup order is seen before the register reads
        `WAITC(rails.core_en, 40)
        `CHK("up", 2'b10, {rails.core_en, rails.main_en})
        `WAITC(rails.main_en, 20)
        wt(3);
        `CHK("ldo", 2'b11, {rails.ldo1_en, rails.ldo_two_en})
        rd_chk(psq_pkg::ADDR_LDO_CTRL, psq_pkg::RST_LDO_CTRL);
        rd_chk(psq_pkg::ADDR_UVLO, psq_pkg::RST_UVLO);
        rd_chk(psq_pkg::ADDR_CONV_A, psq_pkg::RST_CONV_A);
        rd_chk(4'hf, 8'h00);
        rd_chk(psq_pkg::ADDR_RAILS, 8'h0f);
        wr_reg(psq_pkg::ADDR_STATUS, 8'h00);
        rd_chk(psq_pkg::ADDR_STATUS, 8'h03);
        wr_reg(psq_pkg::ADDR_UVLO, 8'h05);
        wt(1);
        `CHK("uvlo", 8'h05, uvlo)
        fault(1'b0, 1'b0);
        // Short glitch must not shut rails down
        @(posedge clk);
        sense.below_uvlo <= 1'b1;
        wt(2);
        sense.below_uvlo <= 1'b0;
        wt(30);
        `CHK("cancel", 2'b11, {rails.core_en, rails.main_en})
        sense.over_temp <= 1'b1;
        wt(30);
        `CHK("ot off", 1'b1, fail_n)
        sense.over_temp <= 1'b0;
        wr_reg(psq_pkg::ADDR_CONV_A, 8'h80);
        fault(1'b1, 1'b1);
        wr_reg(psq_pkg::ADDR_CONV_A, 8'h00);
        sense.auto_fixed <= 1'b1;
        fault(1'b1, 1'b0);
        sense.ldo1_low <= 1'b1;
        sense.ldo1_ok <= 1'b0;
        `WAITC(irq, 10)
        `CHK("irq", 1'b1, irq)
        rd_chk(psq_pkg::ADDR_STATUS, 8'h02);
        sense.ldo1_low <= 1'b0;
        sense.ldo1_ok <= 1'b1;
        wr_reg(psq_pkg::ADDR_LDO_CTRL, 8'h80);
        sense.ldo_two_low <= 1'b1;
        sense.ldo_two_ok <= 1'b0;
        wt(10);
        `CHK("ldo_two", 1'b0, rails.ldo_two_en)
        `CHK("irq", 1'b0, irq)
        rd_chk(psq_pkg::ADDR_STATUS, 8'h01);
        // Sleep entry and exit by pushbutton, warm restart and allow cleared
        wr_reg(psq_pkg::ADDR_CONV_B, 8'h85);
        i_proc.set_sleep(1'b1);
        wt(10);
        `CHK("slp", 1'b0, slp_mode)
        `CHK("code", 8'h05, slp_code)
        wr_reg(psq_pkg::ADDR_CONV_A, 8'h40);
        wt(8);
        `CHK("slp", 2'b10, {slp_mode, rails.core_en})
        i_proc.press_wake();
        wt(8);
        `CHK("wake", 1'b0, slp_mode)
        i_proc.toggle_sleep();
        wt(8);
        `CHK("again", 1'b1, slp_mode)
        i_proc.warm_pulse();
        wt(8);
        `CHK("warm", 1'b0, slp_mode)
        wr_reg(psq_pkg::ADDR_CONV_A, 8'h00);
        wr_reg(psq_pkg::ADDR_CONV_A, 8'h40);
        wt(8);
        `CHK("bit", 1'b1, slp_mode)
        wr_reg(psq_pkg::ADDR_CONV_A, 8'h00);
        wt(8);
        `CHK("allow", 1'b0, slp_mode)
        i_proc.set_sleep(1'b0);
        sense.ext_supply <= 1'b1;
        i_proc.set_sleep(1'b1);
        wt(10);
        `CHK("wait", 1'b0, wait_mode)
        i_proc.set_sleep(1'b0);
        wr_reg(psq_pkg::ADDR_CHG_CFG, 8'h80);
        i_proc.set_sleep(1'b1);
        wt(10);
        `CHK("wait", 1'b1, wait_mode)
        `CHK("chg", 1'b1, chg_en)
        sense.chg_uvlo_ok <= 1'b0;
        wt(8);
        `CHK("chg", 2'b01, {chg_en, fail_n})
        core_sel <= 1'b1;
        main_sel <= 1'b1;
        wt(2);
        `CHK("core", psq_pkg::CORE_MV_HI, core_mv)
        `CHK("main", psq_pkg::MAIN_MV_HI, main_mv)
        report_and_stop();
    end
endmodule : psq_top_tb_top
